// file: dac_host.sv
// Purpose: drive the parallel load, select and update pins of a double-buffered converter
// Assumes: one clock, all pins registered, converter latches are level sensitive
// Notes: one command at a time; requests while busy are dropped silently, bad addresses in idle are flagged
`timescale 1ns/1ps
module dac_host
(
	input wire logic ref_clk_i, // 250 MHz clock
	input wire logic rst_n_i, // synchronous reset, active low
	input wire dac_host_pkg::dac_cmd_t cmd_i, // command from user logic
	output logic busy_o, // sequence in progress
	output logic done_o, // one-cycle pulse at sequence end
	output logic miss_o, // one-cycle pulse, idle command dropped for bad address
	output logic code_valid_o, // converter holds a defined code
	output dac_host_pkg::dac_pins_t pins_o // converter pins
);
	import dac_host_pkg::*;

	host_regs_t r_q;
	host_regs_t r_d;
	logic addr_hit;
	logic [DATA_W-1:0] word_in;

	////////////////////////////////////////////////////////////////////////////////
	// decode and coding

	assign addr_hit = (cmd_i.addr >= ADDR_LO) && (cmd_i.addr <= ADDR_HI);
	// positive-true bits go out unchanged; only signed input is remapped to offset binary
	assign word_in = cmd_i.twos_comp ? (cmd_i.data ^ MSB_FLIP) : cmd_i.data;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb
	begin
		r_d = r_q;
		r_d.done = 1'b0;
		r_d.miss = 1'b0;
		case (r_q.st)
			ST_IDLE:
			begin
				// idle rest level keeps first rank transparent-safe: load high holds it
				r_d.pins.select_n = 1'b1;
				r_d.pins.first_rank_load_n = 1'b1;
				if (cmd_i.valid && addr_hit)
				begin
					r_d.word = word_in;
					r_d.mode = cmd_i.mode;
					r_d.busy = 1'b1;
					r_d.cnt = '0;
					if (cmd_i.mode == MODE_UPDATE)
					begin
						r_d.pins.output_update = 1'b1;
						r_d.st = ST_UPD;
					end
					else if (cmd_i.mode == MODE_EDGE)
					begin
						r_d.pins.data = word_in;
						r_d.pins.select_n = 1'b0;
						r_d.pins.output_update = 1'b0;
						r_d.pins.first_rank_load_n = 1'b0;
						r_d.st = ST_ELOW;
					end
					else
					begin
						r_d.pins.data = word_in;
						r_d.pins.select_n = 1'b0;
						r_d.pins.first_rank_load_n = 1'b0;
						r_d.pins.output_update = 1'b0;
						r_d.st = ST_LOW;
					end
				end
				else if (cmd_i.valid)
				begin
					r_d.miss = 1'b1;
				end
			end
			ST_LOW:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt >= CNT_W'(LOW_CYC - 1))
				begin
					// load strobe rises first so data is caught by it, select lags
					r_d.pins.first_rank_load_n = 1'b1;
					r_d.cnt = '0;
					r_d.loaded = 1'b1;
					r_d.st = ST_HOLD;
				end
			end
			ST_HOLD:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt >= CNT_W'(HOLD_CYC - 1))
				begin
					r_d.pins.select_n = 1'b1;
					r_d.cnt = '0;
					if (r_q.mode == MODE_LOAD_UPDATE)
					begin
						r_d.st = ST_GAP;
					end
					else
					begin
						r_d.st = ST_IDLE;
						r_d.busy = 1'b0;
						r_d.done = 1'b1;
					end
				end
			end
			ST_GAP:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt >= CNT_W'(DESKEW_CYC - 1))
				begin
					r_d.pins.output_update = 1'b1;
					r_d.cnt = '0;
					r_d.st = ST_UPD;
				end
			end
			ST_UPD:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt >= CNT_W'(HIGH_CYC - 1))
				begin
					// update only pulsed, never parked high, so the deskew of rank two is kept
					r_d.pins.output_update = 1'b0;
					r_d.updated = r_q.loaded;
					r_d.cnt = '0;
					r_d.st = ST_IDLE;
					r_d.busy = 1'b0;
					r_d.done = 1'b1;
				end
			end
			ST_ELOW:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				if (r_q.cnt >= CNT_W'(LOW_CYC - 1))
				begin
					// tied pair rises together: first rank freezes, second rank opens
					r_d.pins.select_n = 1'b1;
					r_d.pins.output_update = 1'b1;
					r_d.loaded = 1'b1;
					r_d.cnt = '0;
					r_d.st = ST_EHIGH;
				end
			end
			ST_EHIGH:
			begin
				r_d.cnt = r_q.cnt + 1'b1;
				// high phase stretched so low plus high covers output settling
				if (r_q.cnt >= CNT_W'(SETTLE_CYC - LOW_CYC - 1))
				begin
					r_d.pins.output_update = 1'b0;
					r_d.pins.first_rank_load_n = 1'b1;
					r_d.updated = 1'b1;
					r_d.cnt = '0;
					r_d.st = ST_IDLE;
					r_d.busy = 1'b0;
					r_d.done = 1'b1;
				end
			end
			default:
			begin
				r_d.st = ST_IDLE;
				r_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			r_q <= '0;
			r_q.st <= ST_IDLE;
			// pins never float: select and load inactive, update low so nothing moves
			r_q.pins.select_n <= 1'b1;
			r_q.pins.first_rank_load_n <= 1'b1;
			r_q.pins.output_update <= 1'b0;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign busy_o = r_q.busy;
	assign done_o = r_q.done;
	assign miss_o = r_q.miss;
	assign code_valid_o = r_q.updated;
	assign pins_o = r_q.pins;

endmodule

// file: dac_host_pkg.sv
// Purpose: constants and types for the host-side driver of a double-buffered 16-bit converter
// Assumes: 250 MHz ref_clk_i, converter latches driven straight from flip-flops
// Notes: timing figures are held in ns and turned into cycle counts here
//
// Notes on behaviour
// - wait at least 100 ns after a first-rank load before raising update; load-update mode here waits, a lone update command raises it at once
// - edge mode: update and select tied, load low, rising edge updates
// - edge mode low plus high time must cover output settling
// - update held high keeps second rank transparent, deskew lost
// - two's complement words get their top bit inverted before driving
// - unused controls tie select and load low, update high; never left open; here all three are driven and rest with select and load high, update low
// - in tied wiring rising decoded select makes second rank transparent
// - in tied wiring data is captured by rising load strobe, not select; edge mode here holds load low and captures on rising select
// - slow hosts stretch the load strobe to meet the strobe low time
// - decoder selects on data writes from 3000H through 3400H
package dac_host_pkg;

	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned DATA_W = 16;

	// strobe widths are host choices; the deskew gap is the documented figure
	localparam int unsigned DESKEW_NS = 100;
	localparam int unsigned STROBE_LOW_NS = 40;
	localparam int unsigned STROBE_HIGH_NS = 40;
	localparam int unsigned SETTLE_NS = 13000;
	localparam int unsigned DATA_HOLD_NS = 8;

	localparam int unsigned DESKEW_CYC = (DESKEW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned LOW_CYC = (STROBE_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned HOLD_CYC = (DATA_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam int unsigned CNT_W = 12;

	localparam logic [15:0] ADDR_LO = 16'h3000;
	localparam logic [15:0] ADDR_HI = 16'h3400;
	localparam logic [15:0] MSB_FLIP = 16'h8000;

	// command modes from the user side
	localparam logic [1:0] MODE_LOAD = 2'h0;
	localparam logic [1:0] MODE_UPDATE = 2'h1;
	localparam logic [1:0] MODE_LOAD_UPDATE = 2'h2;
	localparam logic [1:0] MODE_EDGE = 2'h3;

	typedef struct packed {
		logic select_n;
		logic first_rank_load_n;
		logic output_update;
		logic [DATA_W-1:0] data;
	} dac_pins_t;

	typedef struct packed {
		logic valid;
		logic [1:0] mode;
		logic twos_comp;
		logic [15:0] addr;
		logic [DATA_W-1:0] data;
	} dac_cmd_t;

	typedef enum {
		ST_IDLE,
		ST_LOW,
		ST_HOLD,
		ST_GAP,
		ST_UPD,
		ST_ELOW,
		ST_EHIGH
	} host_state_t;

	typedef struct packed {
		host_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [1:0] mode;
		logic [DATA_W-1:0] word;
		logic loaded;
		logic updated;
		logic busy;
		logic done;
		logic miss;
		dac_pins_t pins;
	} host_regs_t;

endpackage

// file: dac_host_properties.sv
// Purpose: port checks for dac_host
// Assumes: pins registered, one clock
// Notes: counts are fixed cycle figures of this build
`timescale 1ns/1ps
module dac_host_properties
import dac_host_pkg::*;
(
	input wire logic ref_clk_i, // clock
	input wire logic rst_n_i, // reset, active low
	input wire dac_cmd_t cmd_i, // command
	input wire logic busy_o, // busy
	input wire logic done_o, // done pulse
	input wire logic miss_o, // miss pulse
	input wire logic code_valid_o, // code defined
	input wire dac_pins_t pins_o // converter pins
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_low;
		(!pins_o.first_rank_load_n) [*8];
	endsequence
	sequence s_kept;
		##1 !pins_o.select_n && $stable(pins_o.data);
	endsequence
	//////////
	property p_miss;
		miss_o |-> $stable(pins_o) && ($past(cmd_i.addr) < ADDR_LO || $past(cmd_i.addr) > ADDR_HI);
	endproperty
	a_miss: assert property (p_miss) else $error("miss without bad address");
	property p_gap;
		$rose(pins_o.output_update) && pins_o.first_rank_load_n && $past(busy_o)
			|-> $past(pins_o.first_rank_load_n, 25) && $past(busy_o, 25);
	endproperty
	a_gap: assert property (p_gap) else $error("update too soon after load");
	property p_tied;
		!pins_o.first_rank_load_n |-> pins_o.select_n == pins_o.output_update;
	endproperty
	a_tied: assert property (p_tied) else $error("select and update differ");
	property p_width;
		$fell(pins_o.first_rank_load_n) |-> s_low;
	endproperty
	a_width: assert property (p_width) else $error("load strobe too short");
	property p_hold;
		$rose(pins_o.first_rank_load_n) && !pins_o.select_n |-> s_kept;
	endproperty
	a_hold: assert property (p_hold) else $error("data not held");
	property p_order;
		$rose(pins_o.select_n) && !pins_o.output_update |-> $past(pins_o.first_rank_load_n);
	endproperty
	a_order: assert property (p_order) else $error("select rose first");
	property p_rest;
		!busy_o |-> pins_o.select_n && pins_o.first_rank_load_n && !pins_o.output_update;
	endproperty
	a_rest: assert property (p_rest) else $error("pins not at rest");
	property p_done;
		done_o |-> $past(busy_o) && !busy_o ##1 !done_o;
	endproperty
	a_done: assert property (p_done) else $error("bad done pulse");
endmodule
bind dac_host dac_host_properties chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.cmd_i(cmd_i), .busy_o(busy_o), .done_o(done_o), .miss_o(miss_o),
	.code_valid_o(code_valid_o), .pins_o(pins_o));

// file: dac_latch_model.sv
// Purpose: two-rank converter input latches
// Assumes: level-sensitive ranks, no clock
// Notes: ranks start unknown
`timescale 1ns/1ps
module dac_latch_model
import dac_host_pkg::*;
(
	input wire dac_pins_t pins_i, // pins from host
	output logic [15:0] rank1_o, // first rank
	output logic [15:0] rank2_o // converter code
);
	always_latch
	begin
		if (!pins_i.select_n && !pins_i.first_rank_load_n)
			rank1_o = pins_i.data;
	end
	// update not gated by select, follows rank1 while high
	always_latch
	begin
		if (pins_i.output_update)
			rank2_o = rank1_o;
	end
endmodule

// file: tb_top.sv
// Purpose: random and corner commands into dac_host
// Assumes: latch model as converter
// Notes: edge mode is long, so it is never drawn at random, only in the two directed runs
`timescale 1ns/1ps
module tb_top;
	import dac_host_pkg::*;
	logic ref_clk_i = 0;
	logic rst_n_i = 0;
	dac_cmd_t cmd_i = '0;
	logic busy_o, done_o, miss_o, code_valid_o;
	dac_pins_t pins_o;
	logic [15:0] r1, r2, e1, e2;
	logic [31:0] rnd = 32'hf692;
	int err_total = 0;
	int checked = 0;
	always #2 ref_clk_i = ~ref_clk_i;
	dac_host uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_i(cmd_i), .busy_o(busy_o),
		.done_o(done_o), .miss_o(miss_o), .code_valid_o(code_valid_o), .pins_o(pins_o));
	dac_latch_model dev (.pins_i(pins_o), .rank1_o(r1), .rank2_o(r2));
	//////////
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// cycles from accept to done, built from the strobe, gap and settle counts
	function automatic logic [15:0] exp_cyc(input logic [1:0] m);
		case (m)
			MODE_LOAD: return 16'(LOW_CYC + HOLD_CYC);
			MODE_UPDATE: return 16'(HIGH_CYC);
			MODE_LOAD_UPDATE: return 16'(LOW_CYC + HOLD_CYC + DESKEW_CYC + HIGH_CYC);
			default: return 16'(SETTLE_CYC);
		endcase
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checked %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic run(input logic [1:0] m, input logic tc, input logic [15:0] a,
		input logic [15:0] d);
		int n;
		logic bad;
		logic [15:0] w;
		bad = a < ADDR_LO || a > ADDR_HI;
		w = tc ? d ^ MSB_FLIP : d;
		@(negedge ref_clk_i);
		cmd_i = {1'b1, m, tc, a, d};
		@(negedge ref_clk_i);
		cmd_i.valid = 0;
		chk({15'h0, miss_o}, {15'h0, bad}, "miss");
		chk({15'h0, busy_o}, {15'h0, !bad}, "busy");
		n = 0;
		while (!bad && !done_o && n < 4000)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		if (n == 4000)
			err_total++;
		if (!bad)
		begin
			chk(16'(n), exp_cyc(m), "cycles");
			chk({15'h0, busy_o}, 16'h0, "busy_end");
		end
		if (!bad && m != MODE_UPDATE)
			e1 = w;
		if (!bad && m != MODE_LOAD)
			e2 = e1;
		chk(r1, e1, "rank1");
		chk(r2, e2, "rank2");
	endtask
	//////////
	initial
	begin
		repeat (20) @(negedge ref_clk_i);
		rst_n_i = 1;
		run(MODE_UPDATE, 0, 16'h3000, 16'h0000);
		chk({15'h0, code_valid_o}, 16'h0, "valid");
		run(MODE_LOAD, 1, 16'h3400, 16'h0000);
		run(MODE_LOAD, 0, 16'h2fff, 16'hffff);
		run(MODE_UPDATE, 0, 16'h3401, 16'h1234);
		run(MODE_UPDATE, 0, 16'h3000, 16'h1234);
		run(MODE_LOAD_UPDATE, 0, 16'h3200, 16'hffff);
		run(MODE_EDGE, 1, 16'h3001, 16'h0000);
		chk({15'h0, code_valid_o}, 16'h1, "valid");
		repeat (14)
		begin
			rnd = lfsr(rnd);
			run(rnd[5:4] == MODE_EDGE ? MODE_LOAD_UPDATE : rnd[5:4], rnd[6],
				rnd[20] ? 16'h3000 + rnd[9:0] : rnd[31:16], rnd[31:16] ^ rnd[15:0]);
		end
		run(MODE_EDGE, 0, 16'h3400, rnd[15:0]);
		end_sim();
	end
	initial
	begin
		repeat (60000) @(posedge ref_clk_i);
		err_total++;
		end_sim();
	end
endmodule
